// file: hw/packer_pkg.sv
package packer_pkg;
   // sample and byte geometry
   localparam int PIX_W = 12;
   localparam int BYTE_W = 8;
   localparam int NIB_W = 4;
   localparam int HI_MSB = 11;
   localparam int HI_LSB = 4;
   localparam int LO_MSB = 3;
   localparam int BYTES_PER_PAIR = 3;
   // sample code range, unsigned straight binary
   localparam logic [11:0] CODE_MIN = 12'h000;
   localparam logic [11:0] CODE_MAX = 12'hfff;
   // colour of the filter element over a pixel
   localparam logic [1:0] COL_BLUE = 2'h0;
   localparam logic [1:0] COL_GREEN = 2'h1;
   localparam logic [1:0] COL_RED = 2'h2;
   // output word bundled through the skid stage: {row_odd, colour, first, last, byte}
   localparam int OUT_W = BYTE_W + 5;
   localparam int F_LAST = 8;
   localparam int F_FIRST = 9;
   localparam int F_COL = 10;
   localparam int F_ODD = 12;
   localparam logic [1:0] PH_RESET = 2'h0;
   // packing phase within a pixel pair
   typedef enum logic [1:0] {
      PH_EARLY = 2'b00,
      PH_LATE = 2'b01,
      PH_TAIL = 2'b10
   } phase_type;
endpackage

// file: hw/byte_skid_stage.sv
`timescale 1ns/1ps
// two-entry output stage so every downstream signal and the room flag come from flops
module byte_skid_stage #(
   parameter int W = 13
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic out_ready,
   output logic out_valid_r,
   output logic [W-1:0] out_data_r,
   output logic room_r,
   output logic room_nxt
);
   logic skid_valid_r;
   logic [W-1:0] skid_data_r;
   logic out_free;
   logic skid_valid_nxt;

   // push is only offered while room_r, so the skid never overflows
   assign out_free = !out_valid_r || out_ready;
   assign skid_valid_nxt = !out_free && (skid_valid_r || push);
   assign room_nxt = !skid_valid_nxt;

   // output register refills from skid first to keep byte order
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end else if (out_free) begin
         out_valid_r <= skid_valid_r || push;
         out_data_r <= skid_valid_r ? skid_data_r : push_data;
      end
   end

   // skid catches a push made while the downstream stalls
   always_ff @(posedge clk) begin
      if (rst) begin
         skid_valid_r <= 1'b0;
         skid_data_r <= '0;
         room_r <= 1'b1;
      end else begin
         skid_valid_r <= skid_valid_nxt;
         room_r <= room_nxt;
         if (!out_free && push) begin
            skid_data_r <= push_data;
         end
      end
   end
endmodule

// file: hw/raw_colour_12bit_pixel_packer.sv
`timescale 1ns/1ps
module raw_colour_12bit_pixel_packer (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic PIX_VALID,
   output logic PIX_READY,
   input wire logic [11:0] PIX_DATA,
   input wire logic PIX_ROW_END,
   input wire logic PIX_FRAME_START,
   output logic BYTE_VALID,
   input wire logic BYTE_READY,
   output logic [7:0] BYTE_DATA,
   output logic BYTE_FIRST,
   output logic BYTE_LAST,
   output logic [1:0] BYTE_COLOUR,
   output logic BYTE_ROW_ODD
);
   packer_pkg::phase_type phase_r;
   packer_pkg::phase_type phase_nxt;
   logic [packer_pkg::NIB_W-1:0] early_lo_r;
   logic [packer_pkg::BYTE_W-1:0] late_hi_r;
   logic early_last_r;
   logic late_last_r;
   logic row_odd_r;
   logic pair_odd_r;
   logic row_start_r;
   logic pix_ready_r;
   logic room_r;
   logic room_nxt;
   logic accept;
   logic zero_fill;
   logic tail_go;
   logic eff_odd;
   logic push;
   logic [packer_pkg::OUT_W-1:0] push_word;
   logic [packer_pkg::OUT_W-1:0] out_word;
   logic early_last_nxt;
   logic pix_ready_nxt;
   logic in_early;
   logic in_late;
   logic in_tail;
   logic take_early;
   logic take_late;
   logic [packer_pkg::BYTE_W-1:0] pix_hi;
   logic [packer_pkg::NIB_W-1:0] pix_lo;
   logic [1:0] late_colour;
   logic first_flag;

   // filter colour from row parity and position parity
   function automatic logic [1:0] colour_of(input logic odd_row, input logic odd_pos);
      if (!odd_row) begin
         colour_of = odd_pos ? packer_pkg::COL_GREEN : packer_pkg::COL_BLUE;
      end else begin
         colour_of = odd_pos ? packer_pkg::COL_RED : packer_pkg::COL_GREEN;
      end
   endfunction

   // bundle one output byte with its side flags
   function automatic logic [packer_pkg::OUT_W-1:0] pack_word(
      input logic [7:0] b, input logic last, input logic first,
      input logic [1:0] col, input logic odd_row);
      pack_word = {odd_row, col, first, last, b};
   endfunction

   // phase decode shared by the handshake decode, the phase walk and the row tracker
   assign in_early = (phase_r == packer_pkg::PH_EARLY);
   assign in_late = (phase_r == packer_pkg::PH_LATE);
   assign in_tail = (phase_r == packer_pkg::PH_TAIL);

   // handshake decode; a frame start forces the row back to even parity
   assign accept = PIX_VALID && pix_ready_r;
   assign eff_odd = PIX_FRAME_START ? 1'b0 : row_odd_r;
   assign zero_fill = in_late && early_last_r && room_r;
   assign tail_go = in_tail && room_r;
   assign push = accept || zero_fill || tail_go;
   assign take_early = in_early && accept;
   assign take_late = in_late && (accept || zero_fill);

   // sample slices and side flags; bits are only routed, never recoded
   assign pix_hi = PIX_DATA[packer_pkg::HI_MSB:packer_pkg::HI_LSB];
   assign pix_lo = PIX_DATA[packer_pkg::LO_MSB:0];
   assign late_colour = colour_of(pair_odd_r, 1'b1);
   assign first_flag = row_start_r || PIX_FRAME_START;

   // byte formation per phase; the sample bits are copied, never altered
   always_comb begin
      push_word = '0;
      case (phase_r)
         packer_pkg::PH_EARLY: begin
            push_word = pack_word(pix_hi, 1'b0, first_flag,
               colour_of(eff_odd, 1'b0), eff_odd);
         end
         packer_pkg::PH_LATE: begin
            if (early_last_r) begin
               push_word = pack_word({4'h0, early_lo_r}, 1'b0, 1'b0,
                  late_colour, pair_odd_r);
            end else begin
               push_word = pack_word({pix_lo, early_lo_r},
                  1'b0, 1'b0, late_colour, pair_odd_r);
            end
         end
         packer_pkg::PH_TAIL: begin
            push_word = pack_word(late_hi_r, late_last_r, 1'b0,
               late_colour, pair_odd_r);
         end
         default: begin
            push_word = '0;
         end
      endcase
   end

   // phase walk: three bytes per pair, always completed before the next pair
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         packer_pkg::PH_EARLY: begin
            if (accept) begin
               phase_nxt = packer_pkg::PH_LATE;
            end
         end
         packer_pkg::PH_LATE: begin
            if (accept || zero_fill) begin
               phase_nxt = packer_pkg::PH_TAIL;
            end
         end
         packer_pkg::PH_TAIL: begin
            if (tail_go) begin
               phase_nxt = packer_pkg::PH_EARLY;
            end
         end
         default: begin
            phase_nxt = packer_pkg::PH_EARLY;
         end
      endcase
   end

   // ready is registered, so it looks one cycle ahead at phase and room
   assign early_last_nxt = take_early ? PIX_ROW_END : early_last_r;
   assign pix_ready_nxt = room_nxt && ((phase_nxt == packer_pkg::PH_EARLY) ||
      (phase_nxt == packer_pkg::PH_LATE && !early_last_nxt));

   // phase and handshake flops
   always_ff @(posedge MCLK) begin
      if (RST) begin
         phase_r <= packer_pkg::PH_EARLY;
         pix_ready_r <= 1'b0;
         early_last_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         pix_ready_r <= pix_ready_nxt;
         early_last_r <= early_last_nxt;
      end
   end

   // earlier half of the pair: low nibble waits for the later pixel
   always_ff @(posedge MCLK) begin
      if (RST) begin
         early_lo_r <= 4'h0;
         pair_odd_r <= 1'b0;
      end else if (take_early) begin
         early_lo_r <= pix_lo;
         pair_odd_r <= eff_odd;
      end
   end

   // later half: high byte waits one slot for the tail byte
   always_ff @(posedge MCLK) begin
      if (RST) begin
         late_hi_r <= 8'h00;
         late_last_r <= 1'b0;
      end else if (take_late) begin
         late_hi_r <= zero_fill ? 8'h00 : pix_hi;
         late_last_r <= zero_fill ? 1'b1 : PIX_ROW_END;
      end
   end

   // row tracking: parity flips and packing restarts after a row's last byte
   always_ff @(posedge MCLK) begin
      if (RST) begin
         row_odd_r <= 1'b0;
         row_start_r <= 1'b1;
      end else if (tail_go && late_last_r) begin
         row_odd_r <= ~pair_odd_r;
         row_start_r <= 1'b1;
      end else if (take_early) begin
         row_odd_r <= eff_odd;
         row_start_r <= 1'b0;
      end
   end

   // output stage keeps every byte-side port on a flop under backpressure
   byte_skid_stage #(
      .W(packer_pkg::OUT_W)
   ) u_out (
      .clk(MCLK),
      .rst(RST),
      .push(push),
      .push_data(push_word),
      .out_ready(BYTE_READY),
      .out_valid_r(BYTE_VALID),
      .out_data_r(out_word),
      .room_r(room_r),
      .room_nxt(room_nxt)
   );

   // ports straight off the flops; side flags ride in the same word as the byte
   assign PIX_READY = pix_ready_r;
   assign BYTE_DATA = out_word[packer_pkg::BYTE_W-1:0];
   assign BYTE_LAST = out_word[packer_pkg::F_LAST];
   assign BYTE_FIRST = out_word[packer_pkg::F_FIRST];
   assign BYTE_COLOUR = out_word[packer_pkg::F_COL+1:packer_pkg::F_COL];
   assign BYTE_ROW_ODD = out_word[packer_pkg::F_ODD];
endmodule

// file: testbench/packer_asserts.sv
`timescale 1ns/1ps
module packer_asserts (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic PIX_VALID,
   input wire logic PIX_READY,
   input wire logic [11:0] PIX_DATA,
   input wire logic PIX_FRAME_START,
   input wire logic BYTE_VALID,
   input wire logic BYTE_READY,
   input wire logic [7:0] BYTE_DATA,
   input wire logic BYTE_FIRST,
   input wire logic BYTE_LAST,
   input wire logic [1:0] BYTE_COLOUR,
   input wire logic BYTE_ROW_ODD
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // short names; colour codes are blue 0, green 1, red 2
   wire take = PIX_VALID && PIX_READY;
   wire [7:0] hi = PIX_DATA[11:4];
   wire v = BYTE_VALID;
   wire od = BYTE_ROW_ODD;
   wire [1:0] c = BYTE_COLOUR;
   chk_reset_quiet: assert property (disable iff (1'b0) RST |=> !v && !PIX_READY)
      else $error("active in reset");
   chk_stall_hold: assert property (v && !BYTE_READY |=> v && $stable(BYTE_DATA))
      else $error("byte moved in stall");
   chk_pair_rate: assert property (take ##1 take |=> !PIX_READY)
      else $error("no tail slot");
   chk_even_colour: assert property (v && !od |-> c < 2'h2)
      else $error("red on even row");
   chk_odd_colour: assert property (v && od |-> ^c)
      else $error("blue on odd row");
   chk_row_start: assert property (v && BYTE_FIRST |-> c == {1'b0, od} && !BYTE_LAST)
      else $error("row start colour");
   chk_row_end: assert property (v && BYTE_LAST |-> c == {od, !od})
      else $error("row end colour");
   chk_first_data: assert property (take && PIX_FRAME_START && !v |=> BYTE_DATA == $past(hi))
      else $error("first byte wrong");
   // main traffic shapes
   cover property (v && BYTE_READY && BYTE_LAST && od);
   cover property (v && !BYTE_READY);
   cover property (take && PIX_FRAME_START);
endmodule
bind raw_colour_12bit_pixel_packer packer_asserts u_packer_asserts (.MCLK, .RST, .PIX_VALID,
   .PIX_READY, .PIX_DATA, .PIX_FRAME_START, .BYTE_VALID, .BYTE_READY, .BYTE_DATA, .BYTE_FIRST,
   .BYTE_LAST, .BYTE_COLOUR, .BYTE_ROW_ODD);

// file: testbench/byte_sink.sv
`timescale 1ns/1ps
module byte_sink (
   input wire logic clk,
   input wire logic valid,
   input wire logic [12:0] word,
   input wire logic slow,
   output logic ready = 1'b0
);
   logic [1:0] n_r = 2'h0;
   logic [12:0] got[$];
   // log taken bytes; slow mode takes one cycle in three to back up the packer
   always @(posedge clk) begin
      if (valid && ready) got.push_back(word);
      n_r <= n_r == 2'h2 ? 2'h0 : n_r + 2'h1;
      ready <= !slow || n_r == 2'h2;
   end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic RST = 1'b1, PIX_VALID = 1'b0, PIX_ROW_END = 1'b0, PIX_FRAME_START = 1'b0;
   logic MCLK = 1'b0, slow = 1'b0, PIX_READY, BYTE_VALID, BYTE_READY, BYTE_FIRST, BYTE_LAST;
   logic BYTE_ROW_ODD;
   logic [11:0] PIX_DATA = 12'h000;
   logic [7:0] BYTE_DATA;
   logic [1:0] BYTE_COLOUR;
   int failures = 0, checks = 0;
   raw_colour_12bit_pixel_packer u_raw_colour_12bit_pixel_packer (.MCLK, .RST, .PIX_VALID,
      .PIX_READY, .PIX_DATA, .PIX_ROW_END, .PIX_FRAME_START, .BYTE_VALID, .BYTE_READY,
      .BYTE_DATA, .BYTE_FIRST, .BYTE_LAST, .BYTE_COLOUR, .BYTE_ROW_ODD);
   byte_sink u_byte_sink (.clk(MCLK), .valid(BYTE_VALID), .slow(slow), .ready(BYTE_READY),
      .word({BYTE_ROW_ODD, BYTE_COLOUR, BYTE_FIRST, BYTE_LAST, BYTE_DATA}));
   initial forever #50 MCLK = ~MCLK; // 100 ns pixel clock
   task automatic compare(input string s, input logic [12:0] seen, input logic [12:0] exp);
      checks++;
      failures += int'(seen !== exp);
      if (seen !== exp) $display("wrong value %s expected %h seen %h", s, exp, seen);
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic put(input logic [11:0] d, input logic re, input logic fs); // held until taken
      PIX_VALID <= 1'b1;
      PIX_DATA <= d;
      PIX_ROW_END <= re;
      PIX_FRAME_START <= fs;
      do @(posedge MCLK); while (PIX_READY !== 1'b1);
   endtask
   // one row of n pixels; an odd count is judged against a zero partner
   task automatic row(input int n, input logic fs, input logic od, input logic [11:0] b);
      logic [11:0] p[$];
      logic [12:0] e[$];
      u_byte_sink.got.delete();
      for (int i = 0; i <= n; i++) p.push_back(i < n ? b + 12'(i) * 12'h3a7 : 12'h000);
      for (int i = 0; i < n; i++) put(p[i], i == n - 1, fs && i == 0);
      PIX_VALID <= 1'b0;
      for (int i = 0; i < n; i += 2) begin
         e.push_back({od, 1'b0, od, i == 0, 1'b0, p[i][11:4]});
         e.push_back({od, od, !od, 2'b00, p[i + 1][3:0], p[i][3:0]});
         e.push_back({od, od, !od, 1'b0, i + 2 >= n, p[i + 1][11:4]});
      end
      for (int i = 0; i < 99 && u_byte_sink.got.size() < e.size(); i++) @(posedge MCLK);
      compare("count", 13'(u_byte_sink.got.size()), 13'(e.size()));
      foreach (e[i]) compare("byte", u_byte_sink.got[i], e[i]);
   endtask
   task automatic t_reset(); // ready low just after release, high one edge later
      @(negedge MCLK);
      compare("ready", 13'(PIX_READY), 13'h0000);
      @(negedge MCLK);
      compare("ready", 13'(PIX_READY), 13'h0001);
      @(posedge MCLK);
   endtask
   task automatic t_rows(); // full-scale and zero codes, odd length closes on a zero partner
      row(4, 1'b1, 1'b0, 12'hfff);
      row(3, 1'b0, 1'b1, 12'h000);
      row(4, 1'b0, 1'b0, 12'h5a3);
   endtask
   task automatic t_frame_stall(); // parity is odd here; frame start must force even
      slow <= 1'b1;
      row(6, 1'b1, 1'b0, 12'h812);
      slow <= 1'b0;
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (16) @(posedge MCLK);
      RST <= 1'b0;
      t_reset();
      t_rows();
      t_frame_stall();
      conclude();
   end
   // cut a hang short
   initial begin
      repeat (2000) @(posedge MCLK);
      failures++;
      conclude();
   end
endmodule
